// ---- rtl/flash_id_readout.sv ----
/*
  Identification readout slave of a serial NOR flash: decodes the maker/device ID read
  and the identification read and shifts ID bytes out on the serial output.
  Assumes the serial clock, select and input are asynchronous pins sampled by clk,
  with the serial clock at most a small fraction of clk.
*/
// Overview of operation
// R1 - opcode 90H plus address zero returns maker ID then device ID, MSB first, falling edges
// R2 - address 000001H with 90H returns the device ID byte first
// R3 - host lowers select then shifts opcode 9FH on the input line
// R4 - after 9FH device shifts 24 ID bits, maker code first, on falling edges
// R5 - the two bytes after the maker code are memory type then capacity
// R6 - identification read is not decoded while a program or erase cycle runs
// R7 - select high at any time stops output and returns to standby
// R8 - delivered state: array bytes FFH, status register 00H
// R9 - host waits the power-up write delay before any write-type instruction
// R10 - status register write cycle finishes within 100 ms, typically 50 ms
// R11 - command and address bits are sampled on serial clock rising edges
// R12 - write-in-progress flag is one for the whole self-timed cycle, then zero
// R13 - output is high impedance with select high and during opcode and address
`timescale 1ns/10ps
module flash_id_readout #(
  parameter logic [7:0]  MAKER_ID    = 8'h5A, // arbitrary value
  parameter logic [7:0]  DEVICE_ID   = 8'h12, // arbitrary value
  parameter logic [7:0]  MEM_TYPE    = 8'h40, // arbitrary value
  parameter logic [7:0]  MEM_CAPAC   = 8'h13, // arbitrary value
  parameter int unsigned STATUS_WRITE_CYCLES = flash_id_pkg::STATUS_WRITE_CYCLES
) (
  // system clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // serial link pins
  input  wire logic sclk,
  input  wire logic cs_b,
  input  wire logic si,
  output logic      so_out,
  output logic      so_oe,
  // self-timed cycle control from the array side
  input  wire logic busy_start,
  input  wire logic status_write_start,
  // state
  output logic      write_in_progress_flag,
  output logic [7:0] status_reg
);
  if (STATUS_WRITE_CYCLES < 1 ||
      STATUS_WRITE_CYCLES > flash_id_pkg::STATUS_WRITE_MAX_CYC) begin : g_bad_cycles
    $error("status write cycle count out of range");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_OPCODE, ST_ADDR, ST_SHIFT, ST_IGNORE} state_t;

  logic [2:0] pins_sync;
  logic       sclk_s;
  logic       cs_b_s;
  logic       si_s;

  link_sync #(.WIDTH(3), .RESET_VAL(flash_id_pkg::SYNC_RESET)) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .raw_in   ({sclk, cs_b, si}),
    .sync_out (pins_sync)
  );
  assign sclk_s = pins_sync[2];
  assign cs_b_s = pins_sync[1];
  assign si_s   = pins_sync[0];

  state_t      state_q,  state_d;
  logic        sclk_q,   sclk_d;
  logic [4:0]  cnt_q,    cnt_d;
  logic [23:0] sh_in_q,  sh_in_d;
  logic [23:0] sh_out_q, sh_out_d;
  logic [4:0]  out_len_q, out_len_d;
  logic        so_q,     so_d;
  logic        oe_q,     oe_d;
  logic        wip_q,    wip_d;
  logic [31:0] tmr_q,    tmr_d;
  logic        rise;
  logic        fall;

  assign rise = sclk_s & ~sclk_q; // see R11
  assign fall = ~sclk_s & sclk_q;

  always_comb begin
    state_d   = state_q;
    sclk_d    = sclk_s;
    cnt_d     = cnt_q;
    sh_in_d   = sh_in_q;
    sh_out_d  = sh_out_q;
    out_len_d = out_len_q;
    so_d      = so_q;
    oe_d      = oe_q;
    if (cs_b_s) begin
      state_d = ST_IDLE; // see R7
      oe_d    = 1'b0; // see R13
      cnt_d   = 5'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_d = ST_OPCODE; // see R3
          cnt_d   = 5'h00;
          oe_d    = 1'b0;
        end
        ST_OPCODE: begin
          if (rise) begin
            sh_in_d = {sh_in_q[22:0], si_s}; // see R11
            cnt_d   = cnt_q + 5'h01;
            if (cnt_q == 5'(flash_id_pkg::OPCODE_BITS - 1)) begin
              cnt_d = 5'h00;
              if (wip_q) begin
                state_d = ST_IGNORE; // see R6
              end else if ({sh_in_q[6:0], si_s} == flash_id_pkg::OP_READ_IDENT) begin
                // see R4, R5
                sh_out_d  = {MAKER_ID, MEM_TYPE, MEM_CAPAC};
                out_len_d = 5'(flash_id_pkg::IDENT_BITS);
                state_d   = ST_SHIFT;
              end else if ({sh_in_q[6:0], si_s} == flash_id_pkg::OP_READ_MAKER_DEVICE) begin
                state_d = ST_ADDR;
              end else begin
                state_d = ST_IGNORE;
              end
            end
          end
        end
        ST_ADDR: begin
          if (rise) begin
            sh_in_d = {sh_in_q[22:0], si_s};
            cnt_d   = cnt_q + 5'h01;
            if (cnt_q == 5'(flash_id_pkg::ADDR_BITS - 1)) begin
              cnt_d = 5'h00;
              if ({sh_in_q[22:0], si_s} == flash_id_pkg::ADDR_DEVICE_FIRST) begin
                sh_out_d = {DEVICE_ID, MAKER_ID, 8'h00}; // see R2
              end else begin
                sh_out_d = {MAKER_ID, DEVICE_ID, 8'h00}; // see R1
              end
              out_len_d = 5'(flash_id_pkg::MAKER_DEV_BITS);
              state_d   = ST_SHIFT;
            end
          end
        end
        ST_SHIFT: begin
          // first fall after the last input bit drives the MSB; the ID word rotates so a
          // host that keeps clocking sees it repeat from its first byte
          if (fall) begin
            oe_d  = 1'b1; // see R1, R4
            so_d  = sh_out_q[23];
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == out_len_q - 5'h01) begin
              cnt_d = 5'h00;
            end
            if (out_len_q == 5'(flash_id_pkg::IDENT_BITS)) begin
              sh_out_d = {sh_out_q[22:0], sh_out_q[23]};
            end else begin
              sh_out_d = {sh_out_q[22:8], sh_out_q[23], 8'h00};
            end
          end
        end
        ST_IGNORE: begin
          oe_d = 1'b0;
        end
        default: state_d = ST_IDLE;
      endcase
    end
  end

  // self-timed status write: flag set wins over completion in the same cycle
  always_comb begin
    wip_d = wip_q;
    tmr_d = tmr_q;
    if (busy_start || status_write_start) begin
      wip_d = 1'b1; // see R12
      tmr_d = 32'(STATUS_WRITE_CYCLES);
    end else if (wip_q) begin
      if (tmr_q <= 32'h00000001) begin
        wip_d = 1'b0; // see R10, R12
        tmr_d = 32'h00000000;
      end else begin
        tmr_d = tmr_q - 32'h00000001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q   <= ST_IDLE;
      sclk_q    <= 1'b0;
      cnt_q     <= 5'h00;
      sh_in_q   <= 24'h000000;
      sh_out_q  <= 24'h000000;
      out_len_q <= 5'h00;
      so_q      <= 1'b0;
      oe_q      <= 1'b0;
      wip_q     <= 1'b0;
      tmr_q     <= 32'h00000000;
    end else begin
      state_q   <= state_d;
      sclk_q    <= sclk_d;
      cnt_q     <= cnt_d;
      sh_in_q   <= sh_in_d;
      sh_out_q  <= sh_out_d;
      out_len_q <= out_len_d;
      so_q      <= so_d;
      oe_q      <= oe_d;
      wip_q     <= wip_d;
      tmr_q     <= tmr_d;
    end
  end

  // status held at its delivered value; array contents live outside this block
  logic [7:0] status_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status_q <= flash_id_pkg::STATUS_DELIVERED; // see R8
    end else begin
      status_q <= status_q;
    end
  end

  assign so_out                 = so_q;
  assign so_oe                  = oe_q;
  assign write_in_progress_flag = wip_q;
  assign status_reg             = status_q;

  a_oe_off_select: assert property (@(posedge clk) disable iff (!rst_b)
    cs_b_s |=> !oe_q) else $error("output driven with select high"); // see R13
  a_oe_off_busy: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == ST_IGNORE) |-> !oe_q) else $error("output driven while ignoring"); // see R6
  a_oe_only_shift: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == ST_OPCODE || state_q == ST_ADDR) |-> !oe_q)
    else $error("output driven in opcode or address phase"); // see R13
  a_wip_set: assert property (@(posedge clk) disable iff (!rst_b)
    status_write_start |=> wip_q) else $error("busy flag not set"); // see R12
  a_wip_len: assert property (@(posedge clk) disable iff (!rst_b)
    ($rose(wip_q) && tmr_q > 32'h00000002) |=> wip_q) else $error("busy flag fell early"); // see R10
  a_ident_first: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == ST_OPCODE && state_d == ST_SHIFT) |=> sh_out_q[23:16] == MAKER_ID)
    else $error("identification not led by maker code"); // see R4
  a_dev_first: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == ST_ADDR && state_d == ST_SHIFT &&
     {sh_in_q[22:0], si_s} == flash_id_pkg::ADDR_DEVICE_FIRST) |=> sh_out_q[23:16] == DEVICE_ID)
    else $error("device ID not first"); // see R2
  a_busy_ignore: assert property (@(posedge clk) disable iff (!rst_b)
    (state_q == ST_OPCODE && wip_q && state_d != ST_OPCODE && !cs_b_s) |=> state_q == ST_IGNORE)
    else $error("command decoded while busy"); // see R6

  sequence select_released;
    $rose(cs_b_s);
  endsequence

  a_stop_select: assert property (@(posedge clk) disable iff (!rst_b) // see R7
    select_released |=> (state_q == ST_IDLE && !oe_q)) else $error("output kept after deselect");
endmodule : flash_id_readout

// ---- rtl/flash_id_pkg.sv ----
/*
  Constants for the serial flash identification readout block: opcodes, ID read addresses, delivered byte values,
  bit counts and self-timed cycle durations.
  Assumes a 20 MHz system clock that oversamples the serial link.
*/
package flash_id_pkg;
  localparam int unsigned CLK_HZ                = 20000000;
  localparam logic [7:0]  OP_READ_MAKER_DEVICE  = 8'h90;
  localparam logic [7:0]  OP_READ_IDENT         = 8'h9F;
  localparam logic [23:0] ADDR_MAKER_FIRST      = 24'h000000;
  localparam logic [23:0] ADDR_DEVICE_FIRST     = 24'h000001;
  localparam logic [7:0]  ERASED_BYTE           = 8'hFF;
  localparam logic [7:0]  STATUS_DELIVERED      = 8'h00;
  localparam int unsigned OPCODE_BITS           = 8;
  localparam int unsigned ADDR_BITS             = 24;
  localparam int unsigned IDENT_BITS            = 24;
  localparam int unsigned MAKER_DEV_BITS        = 16;
  // status write cycle: typical 50 ms, longest 100 ms (count uses typical, longest bounds it)
  localparam int unsigned STATUS_WRITE_TYP_MS   = 50;
  localparam int unsigned STATUS_WRITE_MAX_MS   = 100;
  localparam int unsigned STATUS_WRITE_CYCLES   = (CLK_HZ / 1000) * STATUS_WRITE_TYP_MS;
  localparam int unsigned STATUS_WRITE_MAX_CYC  = (CLK_HZ / 1000) * STATUS_WRITE_MAX_MS;
  // power-up write delay seen by the host: 1 ms least, 10 ms most
  localparam int unsigned POWER_UP_WRITE_MIN_MS = 1;
  localparam int unsigned POWER_UP_WRITE_MAX_MS = 10;
  localparam int unsigned POWER_UP_WRITE_CYC    = (CLK_HZ / 1000) * POWER_UP_WRITE_MIN_MS;
  // synchroniser reset levels {sclk, select, input}: the idle pin levels, so no false edge
  localparam logic [2:0]  SYNC_RESET            = 3'h2;
endpackage : flash_id_pkg

// ---- rtl/link_sync.sv ----
/*
  Two-stage synchroniser for the three serial link inputs.
  Assumes inputs arrive from outside the clk domain; stage one is read only by stage two.
*/
`timescale 1ns/10ps
module link_sync #(
  parameter int unsigned          WIDTH     = 3,
  parameter logic [WIDTH-1:0]     RESET_VAL = '1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // raw pins and synchronised copies
  input  wire logic [WIDTH-1:0] raw_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  if (WIDTH < 1) begin : g_bad_width
    $error("synchroniser width must be at least one");
  end

  always_comb begin
    meta_d = raw_in;
    sync_d = meta_q;
  end

  // reset to the idle pin levels so an edge detector behind us sees nothing after reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : link_sync

// ---- verif/spi_host.sv ----
/*
  Host-side model of the serial link: selects the device, shifts a command, reads bits.
  Assumes a 20 MHz clk and a serial clock half period of four clk cycles.
*/
`timescale 1ns/10ps
module spi_host (
  // system clock
  input  wire logic clk,
  // serial link, host side
  output logic      sclk,
  output logic      cs_b,
  output logic      si,
  input  wire logic so_out,
  input  wire logic so_oe
);
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    si   = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk

  // serial clock only moves inside a frame; read bits are taken just before the next fall
  task automatic frame(input logic [31:0] cmd, input int nb, input int rb,
                       output logic [23:0] rd, output logic [31:0] rd_oe, output logic cmd_oe);
    rd     = 24'h000000;
    rd_oe  = 32'h00000000;
    cmd_oe = 1'b0;
    @(posedge clk);
    cs_b <= 1'b0;
    for (int i = nb - 1; i >= 0; i--) begin
      si <= cmd[i];
      wait_clk(4);
      sclk <= 1'b1;
      wait_clk(4);
      cmd_oe |= so_oe;
      sclk <= 1'b0;
    end
    si <= ~cmd[0];
    for (int i = 0; i < rb; i++) begin
      wait_clk(4);
      sclk <= 1'b1;
      wait_clk(4);
      rd = {rd[22:0], so_out};
      rd_oe += {31'h00000000, so_oe};
      si <= ~si;
      sclk <= 1'b0;
    end
    wait_clk(4);
    cs_b <= 1'b1;
  endtask : frame
endmodule : spi_host

// ---- verif/flash_id_readout_tb.sv ----
/*
  Self-checking bench for the identification readout block.
  Assumes the host model drives the link and the bench drives the cycle-start pulses.
*/
`timescale 1ns/10ps
module flash_id_readout_tb;
  localparam int unsigned SW_CYC = 400;
  localparam logic [7:0] MK = 8'hA3; // arbitrary value
  localparam logic [7:0] DV = 8'h3C; // arbitrary value
  localparam logic [7:0] TY = 8'h21; // arbitrary value
  localparam logic [7:0] CP = 8'h15; // arbitrary value
  logic        clk, rst_b, sclk, cs_b, si, so_out, so_oe;
  logic        busy_start, status_write_start, write_in_progress_flag;
  logic [7:0]  status_reg;
  logic [23:0] rd;
  logic [31:0] cnt;
  logic        coe;
  int          mismatches = 0;
  int          checked = 0;

  flash_id_readout #(.MAKER_ID(MK), .DEVICE_ID(DV), .MEM_TYPE(TY), .MEM_CAPAC(CP),
    .STATUS_WRITE_CYCLES(SW_CYC)) dut_u (.clk(clk), .rst_b(rst_b), .sclk(sclk),
    .cs_b(cs_b), .si(si), .so_out(so_out), .so_oe(so_oe), .busy_start(busy_start),
    .status_write_start(status_write_start),
    .write_in_progress_flag(write_in_progress_flag), .status_reg(status_reg));
  spi_host host_u (.clk(clk), .sclk(sclk), .cs_b(cs_b), .si(si), .so_out(so_out),
    .so_oe(so_oe));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  task automatic t_ident;
    host_u.frame({24'h000000, flash_id_pkg::OP_READ_IDENT}, 8, 24, rd, cnt, coe);
    check({8'h00, rd}, {8'h00, MK, TY, CP});
    check(cnt, 32'h00000018);
    check({31'h0, coe}, 32'h0);
    host_u.wait_clk(6);
    check({31'h0, so_oe}, 32'h0);
    $display("done ident");
  endtask : t_ident

  task automatic t_maker;
    for (int a = 0; a < 2; a++) begin
      host_u.frame({flash_id_pkg::OP_READ_MAKER_DEVICE, 23'h0, a[0]}, 32, 24, rd, cnt, coe);
      check({8'h00, rd}, {8'h00, (a == 1) ? {DV, MK, DV} : {MK, DV, MK}});
      check(cnt, 32'h00000018);
      check({31'h0, coe}, 32'h0);
      host_u.wait_clk(6);
    end
    $display("done maker");
  endtask : t_maker

  task automatic t_abort;
    host_u.frame({24'h000000, flash_id_pkg::OP_READ_IDENT}, 8, 5, rd, cnt, coe);
    check({8'h00, rd}, {27'h0, MK[7:3]});
    host_u.wait_clk(6);
    check({31'h0, so_oe}, 32'h0);
    $display("done abort");
    t_ident();
  endtask : t_abort

  task automatic t_busy;
    @(posedge clk);
    busy_start <= 1'b1;
    @(posedge clk);
    busy_start <= 1'b0;
    host_u.frame({24'h000000, flash_id_pkg::OP_READ_IDENT}, 8, 24, rd, cnt, coe);
    check(cnt, 32'h0);
    check({31'h0, write_in_progress_flag}, 32'h1);
    for (int i = 0; i < 400 && write_in_progress_flag; i++) @(posedge clk);
    check({31'h0, write_in_progress_flag}, 32'h0);
    $display("done busy");
    t_ident();
  endtask : t_busy

  task automatic t_status;
    int n;
    host_u.wait_clk(flash_id_pkg::POWER_UP_WRITE_CYC);
    @(posedge clk);
    status_write_start <= 1'b1;
    @(posedge clk);
    status_write_start <= 1'b0;
    #1;
    check({31'h0, write_in_progress_flag}, 32'h1);
    n = 1;
    for (int i = 0; i < 1000 && write_in_progress_flag; i++) begin
      @(posedge clk);
      #1;
      if (write_in_progress_flag) n++;
    end
    check(n, SW_CYC);
    check({24'h0, status_reg}, {24'h0, flash_id_pkg::STATUS_DELIVERED});
    $display("done status");
  endtask : t_status

  initial begin
    rst_b = 1'b0;
    busy_start = 1'b0;
    status_write_start = 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    check({24'h0, status_reg}, {24'h0, flash_id_pkg::STATUS_DELIVERED});
    check({30'h0, write_in_progress_flag, so_oe}, 32'h0);
    t_ident();
    t_maker();
    t_abort();
    t_busy();
    t_status();
    tally_and_finish();
  end

  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule : flash_id_readout_tb
